// ---- logic/psram_spi_device.sv ----
`include "psram_cfg.svh"
`default_nettype none
// Functional notes
// - Storage is byte addressed with a 23-bit address.
// - Bursts advance linearly, crossing pages, while select-low time holds.
// - Power-up state is single-lane mode with quad-enable flag cleared.
// - Single-lane 0x03 reads serially with no wait; refused in quad mode.
// - Single-lane 0x0B reads serially with 8 wait cycles.
// - Single-lane 0xEB: serial command, quad address, 6 waits, quad data.
// - Quad-mode 0x0B uses four lanes throughout with 4 wait cycles.
// - Quad-mode 0xEB uses four lanes throughout with 6 wait cycles.
// - Single-lane 0x02 writes command, address, data serially, no wait.
// - Single-lane 0x38: serial command, quad address and data, no wait.
// - Quad mode takes 0x02 or 0x38 as four-lane write, no wait.
// - Single-lane 0x35 sets quad-enable flag, entering four-lane mode.
// - Quad-mode 0xF5 clears quad-enable flag, back to single lane.
// - Single-lane 0x9F acts as zero-wait read returning identity value.
// - Software reset needs 0x66 immediately followed by 0x99.
// - Any other command after reset-arm cancels the armed state.
// - Completed software reset returns to single-lane standby.
// - Select rising ends every command and returns to standby.
// - Read data is driven from the falling serial clock edge.

// Write buffer between the serial front end and the storage array
module psram_wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign full = (wr_ptr[PW] != rd_ptr[PW])
        && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = store[rd_ptr[PW-1:0]];

    // Entry storage
    always_ff @(posedge core_clk_in) begin
        if (in_valid_in && !full) begin
            store[wr_ptr[PW-1:0]] <= in_data_in;
        end
    end

    // Pointers
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid_in && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready_in && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : psram_wr_fifo

// Serial RAM command front end with its storage array
module psram_spi_device #(
    parameter int MEM_AW = `ADDR_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter logic [7:0] IDENT = `IDENT_DEFAULT, // Arbitrary value
    parameter logic [11:0] INIT_CYCLES = 12'(`INIT_CYCLES)
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic sclk_in,
    input wire logic select_b_in,
    input wire logic [3:0] data_lanes_in,
    output logic [3:0] data_lanes_out,
    output logic [3:0] data_lanes_oe_out,
    output logic four_lane_mode_out,
    output logic init_done_out,
    output logic refresh_blocked_out
);
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic sclk_prev;
    logic rise;
    logic fall;
    logic deselect;
    logic [3:0] lanes;
    psram_pkg::phase_e state;
    psram_pkg::phase_e dec_state;
    logic [4:0] cnt;
    logic [4:0] ocnt;
    logic [3:0] wait_n;
    logic [3:0] dec_wait;
    logic phase_quad;
    logic dec_quad;
    logic is_write;
    logic dec_write;
    logic is_ident;
    logic dec_ident;
    logic dec_qflag;
    logic dec_armed;
    logic armed;
    logic beat_quad;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [23:0] addr_field;
    logic [23:0] next_addr_field;
    logic [`ADDR_W-1:0] addr;
    logic cmd_last;
    logic addr_last;
    logic byte_last;
    logic wait_last;
    logic enter_rdata;
    logic out_last;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    psram_pkg::wr_entry_s fifo_in;
    psram_pkg::wr_entry_s fifo_out;
    logic fetch_req;
    logic [7:0] out_sr;
    logic [7:0] mem [2**MEM_AW];
    logic [11:0] init_cnt;
    logic [7:0] sel_low;

    // Two-stage synchronisers for all pins
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta <= 6'h10;
            pin_sync <= 6'h10;
            sclk_prev <= 1'b0;
        end else begin
            pin_meta <= {sclk_in, select_b_in, data_lanes_in};
            pin_sync <= pin_meta;
            sclk_prev <= pin_sync[5];
        end
    end

    assign deselect = pin_sync[4];
    assign lanes = pin_sync[3:0];
    assign rise = pin_sync[5] && !sclk_prev && !deselect;
    assign fall = !pin_sync[5] && sclk_prev && !deselect;

    // Beat width and MSB-first shifting of the incoming bits
    assign beat_quad = (state == psram_pkg::ST_CMD) ? four_lane_mode_out
        : phase_quad;
    assign next_shift = beat_quad ? {shift[3:0], lanes}
        : {shift[6:0], lanes[0]};
    assign next_addr_field = phase_quad ? {addr_field[19:0], lanes}
        : {addr_field[22:0], lanes[0]};
    assign cmd_last = beat_quad ? (cnt == `LAST_BYTE_QUAD)
        : (cnt == `LAST_BYTE_SINGLE);
    assign byte_last = phase_quad ? (cnt == `LAST_BYTE_QUAD)
        : (cnt == `LAST_BYTE_SINGLE);
    assign addr_last = phase_quad ? (cnt == `LAST_ADDR_QUAD)
        : (cnt == `LAST_ADDR_SINGLE);
    assign wait_last = (cnt == {1'b0, wait_n - 4'h1});

    // Command decode per current mode
    always_comb begin
        dec_state = psram_pkg::ST_IGNORE;
        dec_wait = `WAIT_NONE;
        dec_quad = four_lane_mode_out;
        dec_write = 1'b0;
        dec_ident = 1'b0;
        dec_qflag = four_lane_mode_out;
        dec_armed = 1'b0;
        case (next_shift)
            `OP_READ: begin
                if (!four_lane_mode_out) begin
                    dec_state = psram_pkg::ST_ADDR;
                end
            end
            `OP_FAST_READ: begin
                dec_state = psram_pkg::ST_ADDR;
                dec_wait = four_lane_mode_out ? `WAIT_FAST_QUAD
                    : `WAIT_FAST_SINGLE;
            end
            `OP_QUAD_READ: begin
                dec_state = psram_pkg::ST_ADDR;
                dec_quad = 1'b1;
                dec_wait = `WAIT_QUAD_READ;
            end
            `OP_WRITE: begin
                dec_state = psram_pkg::ST_ADDR;
                dec_write = 1'b1;
            end
            `OP_QUAD_WRITE: begin
                dec_state = psram_pkg::ST_ADDR;
                dec_quad = 1'b1;
                dec_write = 1'b1;
            end
            `OP_QUAD_ON: begin
                if (!four_lane_mode_out) begin
                    dec_qflag = 1'b1;
                end
            end
            `OP_QUAD_OFF: begin
                if (four_lane_mode_out) begin
                    dec_qflag = 1'b0;
                end
            end
            `OP_RESET_ARM: begin
                dec_armed = 1'b1;
            end
            `OP_RESET_EXEC: begin
                if (armed) begin
                    dec_qflag = `QUAD_RESET;
                end
            end
            `OP_IDENT: begin
                if (!four_lane_mode_out) begin
                    dec_state = psram_pkg::ST_ADDR;
                    dec_ident = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    // Frame sequencer; select high returns to command phase once init is done, else to ignore
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= psram_pkg::ST_IGNORE;
            cnt <= 5'h00;
            shift <= 8'h00;
            addr_field <= 24'h000000;
            wait_n <= `WAIT_NONE;
            phase_quad <= 1'b0;
            is_write <= 1'b0;
            is_ident <= 1'b0;
        end else if (deselect) begin
            state <= init_done_out ? psram_pkg::ST_CMD
                : psram_pkg::ST_IGNORE;
            cnt <= 5'h00;
        end else if (rise) begin
            case (state)
                psram_pkg::ST_CMD: begin
                    shift <= next_shift;
                    cnt <= cmd_last ? 5'h00 : cnt + 5'h01;
                    if (cmd_last) begin
                        state <= dec_state;
                        wait_n <= dec_wait;
                        phase_quad <= dec_quad;
                        is_write <= dec_write;
                        is_ident <= dec_ident;
                    end
                end
                psram_pkg::ST_ADDR: begin
                    addr_field <= next_addr_field;
                    cnt <= addr_last ? 5'h00 : cnt + 5'h01;
                    if (addr_last) begin
                        if (is_write) begin
                            state <= psram_pkg::ST_WDATA;
                        end else if (wait_n == `WAIT_NONE) begin
                            state <= psram_pkg::ST_RDATA;
                        end else begin
                            state <= psram_pkg::ST_WAIT;
                        end
                    end
                end
                psram_pkg::ST_WAIT: begin
                    cnt <= wait_last ? 5'h00 : cnt + 5'h01;
                    if (wait_last) begin
                        state <= psram_pkg::ST_RDATA;
                    end
                end
                psram_pkg::ST_WDATA: begin
                    shift <= next_shift;
                    cnt <= byte_last ? 5'h00 : cnt + 5'h01;
                end
                default: begin
                end
            endcase
        end
    end

    // Mode flag and reset arming, updated as each command byte lands
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            four_lane_mode_out <= `QUAD_RESET;
            armed <= 1'b0;
        end else if (rise && state == psram_pkg::ST_CMD && cmd_last) begin
            four_lane_mode_out <= dec_qflag;
            armed <= dec_armed;
        end
    end

    // Burst events
    assign enter_rdata = rise && !is_write
        && ((state == psram_pkg::ST_ADDR && addr_last
        && wait_n == `WAIT_NONE)
        || (state == psram_pkg::ST_WAIT && wait_last));
    assign out_last = fall && state == psram_pkg::ST_RDATA
        && (phase_quad ? (ocnt == `LAST_BYTE_QUAD)
        : (ocnt == `LAST_BYTE_SINGLE));
    assign push = rise && state == psram_pkg::ST_WDATA && byte_last;

    // Byte address: load, then advance linearly with wrap
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr <= '0;
        end else if (rise && state == psram_pkg::ST_ADDR && addr_last) begin
            addr <= next_addr_field[`ADDR_W-1:0];
        end else if ((push && fifo_in_ready) || out_last) begin
            addr <= addr + 1'b1;
        end
    end

    // Write bytes queue up; a full buffer drops the byte
    assign fifo_in.addr = addr;
    assign fifo_in.data = next_shift;

    psram_wr_fifo #(
        .WIDTH($bits(psram_pkg::wr_entry_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(!fetch_req),
        .out_data_out(fifo_out)
    );

    // Array write; a pending read fetch stalls the drain
    always_ff @(posedge core_clk_in) begin
        if (fifo_out_valid && !fetch_req) begin
            mem[fifo_out.addr[MEM_AW-1:0]] <= fifo_out.data;
        end
    end

    // Fetch request for the next read byte
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fetch_req <= 1'b0;
        end else begin
            fetch_req <= enter_rdata || out_last;
        end
    end

    // Read shifter and lane drivers, stepping on falling edges
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_sr <= 8'h00;
            ocnt <= 5'h00;
            data_lanes_out <= 4'h0;
            data_lanes_oe_out <= 4'h0;
        end else if (deselect) begin
            ocnt <= 5'h00;
            data_lanes_out <= 4'h0;
            data_lanes_oe_out <= 4'h0;
        end else if (fetch_req) begin
            out_sr <= is_ident ? IDENT : mem[addr[MEM_AW-1:0]];
        end else if (fall && state == psram_pkg::ST_RDATA) begin
            ocnt <= out_last ? 5'h00 : ocnt + 5'h01;
            if (phase_quad) begin
                data_lanes_out <= out_sr[7:4];
                data_lanes_oe_out <= 4'hf;
                out_sr <= {out_sr[3:0], 4'h0};
            end else begin
                data_lanes_out <= {2'b00, out_sr[7], 1'b0};
                data_lanes_oe_out <= 4'h2;
                out_sr <= {out_sr[6:0], 1'b0};
            end
        end
    end

    // Self-initialisation time after reset release
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            init_cnt <= 12'h000;
            init_done_out <= 1'b0;
        end else if (!init_done_out) begin
            init_cnt <= init_cnt + 12'h001;
            init_done_out <= (init_cnt == INIT_CYCLES - 12'h001);
        end
    end

    // Flags a select-low period long enough to stall refresh
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_low <= 8'h00;
            refresh_blocked_out <= 1'b0;
        end else if (deselect) begin
            sel_low <= 8'h00;
            refresh_blocked_out <= 1'b0;
        end else begin
            if (!refresh_blocked_out) begin
                sel_low <= sel_low + 8'h01;
            end
            refresh_blocked_out <=
                (sel_low >= 8'(`MAX_SELECT_LOW_CYCLES));
        end
    end
endmodule : psram_spi_device
`default_nettype wire

// ---- logic/psram_cfg.svh ----
`ifndef PSRAM_CFG_SVH
`define PSRAM_CFG_SVH
// Command codes
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_QUAD_READ 8'heb
`define OP_WRITE 8'h02
`define OP_QUAD_WRITE 8'h38
`define OP_QUAD_ON 8'h35
`define OP_QUAD_OFF 8'hf5
`define OP_RESET_ARM 8'h66
`define OP_RESET_EXEC 8'h99
`define OP_IDENT 8'h9f
// Wait cycles per read kind
`define WAIT_NONE 4'h0
`define WAIT_FAST_SINGLE 4'h8
`define WAIT_FAST_QUAD 4'h4
`define WAIT_QUAD_READ 4'h6
// Last beat index of a byte and of the 24-bit address field
`define LAST_BYTE_SINGLE 5'h07
`define LAST_BYTE_QUAD 5'h01
`define LAST_ADDR_SINGLE 5'h17
`define LAST_ADDR_QUAD 5'h05
// Widths and reset values
`define ADDR_W 23
`define FIFO_DEPTH 32
`define QUAD_RESET 1'b0
`define IDENT_DEFAULT 8'h5a
// Timing: core clock rate and documented times
`define CLK_MHZ 10
`define INIT_TIME_US 150
`define MAX_SELECT_LOW_US 4
`define INIT_CYCLES (`INIT_TIME_US * `CLK_MHZ)
`define MAX_SELECT_LOW_CYCLES (`MAX_SELECT_LOW_US * `CLK_MHZ)
`endif

// ---- logic/psram_pkg.sv ----
`include "psram_cfg.svh"
`default_nettype none
package psram_pkg;
    // Protocol phases of one select-low frame
    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_WAIT, ST_RDATA, ST_WDATA, ST_IGNORE
    } phase_e;
    // One buffered write: target byte and its data
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [7:0] data;
    } wr_entry_s;
endpackage : psram_pkg
`default_nettype wire

// ---- dv/psram_spi_device_sva.sv ----
`default_nettype none
module psram_spi_device_sva #(
    parameter logic [11:0] INIT_CYCLES = 12'h010
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic sclk_in,
    input wire logic select_b_in,
    input wire logic [3:0] data_lanes_out,
    input wire logic [3:0] data_lanes_oe_out,
    input wire logic four_lane_mode_out,
    input wire logic init_done_out,
    input wire logic refresh_blocked_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] up_cnt;
    logic [5:0] low_cnt;
    // Cycles since reset release, saturating
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_cnt <= 12'h000;
        end else if (up_cnt != 12'hfff) begin
            up_cnt <= up_cnt + 12'h001;
        end
    end
    // Cycles with select held low, saturating
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_cnt <= 6'h00;
        end else if (select_b_in) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Steps: select seen high long enough, lane drive starting
    sequence s_deselected;
        select_b_in [*5];
    endsequence
    sequence s_lane_rise;
        $rose(|data_lanes_oe_out);
    endsequence
    a_init_early: assert property (
        up_cnt < INIT_CYCLES - 12'h002 |-> !init_done_out)
        else $error("init done too early");
    a_init_late: assert property (
        up_cnt > INIT_CYCLES + 12'h002 |-> init_done_out)
        else $error("init done too late");
    a_idle_hiz: assert property (
        s_deselected |-> data_lanes_oe_out == 4'h0)
        else $error("lanes driven while deselected");
    a_idle_refresh: assert property (
        s_deselected |-> !refresh_blocked_out)
        else $error("refresh still blocked while deselected");
    a_refresh_set: assert property (
        low_cnt == 6'h2e |-> refresh_blocked_out)
        else $error("long select low not flagged");
    a_refresh_early: assert property (
        refresh_blocked_out && !select_b_in |-> low_cnt >= 6'h26)
        else $error("refresh flagged too early");
    a_oe_codes: assert property (
        data_lanes_oe_out inside {4'h0, 4'h2, 4'hf})
        else $error("illegal lane enable pattern");
    a_oe_single: assert property (
        data_lanes_oe_out == 4'h2 |-> !four_lane_mode_out)
        else $error("single lane drive in four lane mode");
    a_drive_on_fall: assert property (
        s_lane_rise |-> !$past(sclk_in, 2) || !$past(sclk_in, 3)
        || !$past(sclk_in, 4))
        else $error("lane drive not after clock fall");
    a_mode_in_frame: assert property (
        $changed(four_lane_mode_out)
        |-> !$past(select_b_in, 3) || !$past(select_b_in, 4))
        else $error("mode changed outside a frame");
    a_no_early_drive: assert property (
        !init_done_out |-> data_lanes_oe_out == 4'h0)
        else $error("lanes driven before init");
endmodule : psram_spi_device_sva
`default_nettype wire

// ---- dv/psram_host_model.sv ----
`default_nettype none
module psram_host_model (
    input wire logic core_clk_in,
    input wire logic [3:0] lanes_in,
    output logic sclk_out,
    output logic select_b_out,
    output logic [3:0] lanes_out,
    output logic [3:0] lanes_oe_out,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels: clock low, select high, lanes low
    initial begin
        sclk_out = 1'b0;
        select_b_out = 1'b1;
        lanes_out = 4'h0;
        lanes_oe_out = 4'h0;
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
    end
    // One clock beat; released lanes show the inverse of their last value
    task automatic beat(input logic [3:0] v, input logic [3:0] oe,
                        output logic [3:0] r);
        @(negedge core_clk_in);
        sclk_out = 1'b0;
        lanes_oe_out = oe;
        lanes_out = (v & oe) | (~lanes_out & ~oe);
        repeat (5) @(negedge core_clk_in);
        r = lanes_in;
        sclk_out = 1'b1;
        repeat (2) @(negedge core_clk_in);
    endtask : beat
    // Byte out, high bit or high nibble first
    task automatic put_byte(input logic [7:0] b, input logic q);
        logic [3:0] r;
        if (q) begin
            beat(b[7:4], 4'hf, r);
            beat(b[3:0], 4'hf, r);
        end else begin
            for (int i = 7; i >= 0; i--) beat({3'b000, b[i]}, 4'h1, r);
        end
    endtask : put_byte
    // Byte in, taken on rising clock; single lane reads lane 1
    task automatic get_byte(input logic q, input logic rep,
                            output logic [7:0] b);
        logic [3:0] r;
        b = 8'h00;
        for (int i = 0; i < (q ? 2 : 8); i++) begin
            beat(4'h0, 4'h0, r);
            b = q ? {b[3:0], r} : {b[6:0], r[1]};
        end
        if (rep) begin
            @(negedge core_clk_in);
            rx_byte_out = b;
            rx_valid_out = 1'b1;
            @(negedge core_clk_in);
            rx_valid_out = 1'b0;
        end
    endtask : get_byte
    // Wait beats with lanes released
    task automatic wait_beats(input int n);
        logic [3:0] r;
        repeat (n) beat(4'h0, 4'h0, r);
    endtask : wait_beats
    task automatic open_frame();
        @(negedge core_clk_in);
        select_b_out = 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask : open_frame
    // End with clock low, then hold select high between frames
    task automatic close_frame();
        @(negedge core_clk_in);
        sclk_out = 1'b0;
        lanes_oe_out = 4'h0;
        lanes_out = ~lanes_out;
        repeat (2) @(negedge core_clk_in);
        select_b_out = 1'b1;
        repeat (8) @(negedge core_clk_in);
    endtask : close_frame
endmodule : psram_host_model
`default_nettype wire

// ---- dv/tb_psram_spi_device.sv ----
`include "psram_cfg.svh"
`default_nettype none
module tb_psram_spi_device;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value
    localparam logic [11:0] INIT_CYCLES = 12'h010;
    logic core_clk_in, rst_b_in, sclk, sel_b, mode, init_done, blocked;
    logic rx_valid, seen_oe;
    logic [3:0] lanes, h_val, h_oe, d_val, d_oe;
    logic [7:0] rx_byte;
    logic [7:0] shadow [1024];
    logic [7:0] exp_q [$];
    int n_errors = 0;
    int n_tests = 0;
    // Wire level: device value where the device drives, else the host value
    assign lanes = (d_oe & d_val) | (~d_oe & h_val);
    psram_spi_device #(.MEM_AW(10), .FIFO_DEPTH(32), .IDENT(IDENT),
        .INIT_CYCLES(INIT_CYCLES)) dut_u (.core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in), .sclk_in(sclk), .select_b_in(sel_b),
        .data_lanes_in(lanes), .data_lanes_out(d_val),
        .data_lanes_oe_out(d_oe), .four_lane_mode_out(mode),
        .init_done_out(init_done), .refresh_blocked_out(blocked));
    psram_host_model host_u (.core_clk_in(core_clk_in), .lanes_in(lanes),
        .sclk_out(sclk), .select_b_out(sel_b), .lanes_out(h_val),
        .lanes_oe_out(h_oe), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid));
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // Watch for lane drive during a frame
    always @(posedge core_clk_in) begin
        if (d_oe !== 4'h0) seen_oe <= 1'b1;
        if ((d_oe & h_oe) !== 4'h0) begin
            check("lane clash", {4'h0, d_oe & h_oe}, 8'h00);
        end
    end
    // Compare each received byte with the oldest note
    always @(posedge core_clk_in) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) check("read count", 8'h01, 8'h00);
            else check("read byte", rx_byte, exp_q.pop_front());
        end
    end
    // One frame: command, address bytes, waits, data; notes expectations
    task automatic frame(input logic [7:0] cmd, input logic qc,
        input logic qa, input logic [23:0] a, input int na, input int nw,
        input int nd, input logic rd, input logic qd, input logic ok);
        logic [7:0] b;
        seen_oe = 1'b0;
        host_u.open_frame();
        host_u.put_byte(cmd, qc);
        for (int i = 0; i < na; i++) host_u.put_byte(a[23-8*i -: 8], qa);
        host_u.wait_beats(nw);
        for (int i = 0; i < nd; i++) begin
            if (rd) begin
                if (ok && cmd == `OP_IDENT) exp_q.push_back(IDENT);
                else if (ok) exp_q.push_back(shadow[10'(a + 24'(i))]);
                host_u.get_byte(qd, ok, b);
            end else begin
                b = 8'($urandom);
                if (ok) shadow[10'(a + 24'(i))] = b;
                host_u.put_byte(b, qd);
            end
        end
        host_u.close_frame();
    endtask : frame
    task automatic chk_mode(input logic e);
        check("four lane mode", {7'h00, mode}, {7'h00, e});
    endtask : chk_mode
    task automatic chk_quiet();
        check("lane drive", {7'h00, seen_oe}, 8'h00);
    endtask : chk_quiet
    task automatic run_all();
        frame(`OP_RESET_ARM, 0, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        frame(`OP_RESET_EXEC, 0, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b0);
        $display("test reset pair done");
        frame(`OP_WRITE, 0, 0, 24'h8003fe, 3, 0, 4, 0, 0, 1);
        frame(`OP_READ, 0, 0, 24'h0003fe, 3, 0, 4, 1, 0, 1);
        check("release", {4'h0, d_oe}, 8'h00);
        frame(`OP_FAST_READ, 0, 0, 24'h0003ff, 3, 8, 2, 1, 0, 1);
        frame(`OP_IDENT, 0, 0, 24'h0, 3, 0, 2, 1, 0, 1);
        frame(`OP_QUAD_WRITE, 0, 1, 24'h000100, 3, 0, 3, 0, 1, 1);
        frame(`OP_QUAD_READ, 0, 1, 24'h000100, 3, 6, 3, 1, 1, 1);
        $display("test single lane done");
        frame(`OP_QUAD_OFF, 0, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b0);
        frame(8'ha5, 0, 0, 24'h0, 3, 0, 2, 1, 0, 0);
        chk_quiet();
        frame(`OP_QUAD_ON, 0, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b1);
        frame(`OP_WRITE, 1, 1, 24'h000200, 3, 0, 2, 0, 1, 1);
        frame(`OP_QUAD_WRITE, 1, 1, 24'h000202, 3, 0, 2, 0, 1, 1);
        frame(`OP_FAST_READ, 1, 1, 24'h000200, 3, 4, 4, 1, 1, 1);
        frame(`OP_QUAD_READ, 1, 1, 24'h000202, 3, 6, 2, 1, 1, 1);
        frame(`OP_READ, 1, 1, 24'h000200, 3, 0, 2, 1, 1, 0);
        chk_quiet();
        frame(`OP_IDENT, 1, 1, 24'h0, 3, 0, 2, 1, 1, 0);
        chk_quiet();
        frame(`OP_QUAD_OFF, 1, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b0);
        $display("test quad mode done");
        frame(`OP_QUAD_ON, 0, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        frame(`OP_RESET_ARM, 1, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        frame(`OP_FAST_READ, 1, 1, 24'h000200, 3, 4, 1, 1, 1, 1);
        frame(`OP_RESET_EXEC, 1, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b1);
        frame(`OP_RESET_ARM, 1, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        frame(`OP_RESET_EXEC, 1, 0, 24'h0, 0, 0, 0, 0, 0, 1);
        chk_mode(1'b0);
        frame(`OP_READ, 0, 0, 24'h000100, 3, 0, 2, 1, 0, 1);
        $display("test software reset done");
    endtask : run_all
    initial begin
        rst_b_in = 1'b0;
        void'($urandom(78619));
        repeat (3) @(negedge core_clk_in);
        rst_b_in = 1'b1;
        chk_mode(1'b0);
        check("init done", {7'h00, init_done}, 8'h00);
        for (int i = 0; i < 200 && init_done !== 1'b1; i++) begin
            @(negedge core_clk_in);
        end
        if (init_done !== 1'b1) n_errors++;
        else run_all();
        check("notes left", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule : tb_psram_spi_device
bind psram_spi_device psram_spi_device_sva #(.INIT_CYCLES(INIT_CYCLES))
    chk_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .sclk_in(sclk_in), .select_b_in(select_b_in),
    .data_lanes_out(data_lanes_out), .data_lanes_oe_out(data_lanes_oe_out),
    .four_lane_mode_out(four_lane_mode_out), .init_done_out(init_done_out),
    .refresh_blocked_out(refresh_blocked_out));
`default_nettype wire
